// [pkg/dma_cfg.svh]
// Constants for the two-channel transfer unit
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH
`define ADDR_W          20
`define CNT_W           16
// Register word offsets (byte addresses)
`define OFF_SRC0        8'h00
`define OFF_DST0        8'h04
`define OFF_CNT0        8'h08
`define OFF_CTL0        8'h0C
`define OFF_SRC1        8'h10
`define OFF_DST1        8'h14
`define OFF_CNT1        8'h18
`define OFF_CTL1        8'h1C
`define OFF_UNIT        8'h20
// Control field positions
`define CTL_ARM         0
`define CTL_WORD        1
`define CTL_SINC        2
`define CTL_SDEC        3
`define CTL_DINC        4
`define CTL_DDEC        5
`define CTL_SMEM        6
`define CTL_DMEM        7
`define CTL_SYNC_LO     8
`define CTL_SYNC_HI     9
`define CTL_TC          10
`define CTL_IRQEN       11
`define CTL_PRIO        12
`define CTL_TIMER       13
`define CTL_DONE        14
`define CTL_RST         15'h0000
// Unit control bits
`define UNIT_SUSPEND    0
`define UNIT_NMI_OVR    1
// Timing count and I/O address limit
`define REQ_LAT_CLK     4
`define IO_LIMIT        20'h0FFFF
`endif

// [pkg/dma_pkg.sv]
// Types for the two-channel transfer unit
package dma_pkg;
   typedef enum logic [1:0] {
      SYNC_NONE = 2'h0,
      SYNC_SRC  = 2'h1,
      SYNC_DST  = 2'h2
   } sync_mode_t;
   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_WAIT   = 7'h02,
      ST_FETCH  = 7'h04,
      ST_DEPO   = 7'h08,
      ST_UPD    = 7'h10,
      ST_GAP    = 7'h20,
      ST_RELSE  = 7'h40
   } xfer_state_t;
endpackage : dma_pkg

// [rtl/two_channel_dma_unit.sv]
// Two-channel transfer unit with Wishbone register access
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "dma_cfg.svh"
module two_channel_dma_unit #(
   parameter int BUS16 = 1
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic [1:0]           transfer_request_pin,
   input  wire logic                 timer_max_pulse,
   input  wire logic                 nmi_active,
   output logic                      bus_req,
   input  wire logic                 bus_grant,
   output logic                      cycle_start,
   input  wire logic                 cycle_done,
   output logic      [19:0]          cycle_addr,
   output logic                      cycle_mem,
   output logic                      cycle_write,
   output logic                      cycle_word,
   output logic                      cycle_hi_byte,
   output logic                      cycle_cs_allow,
   output logic      [15:0]          cycle_wdata,
   input  wire logic [15:0]          cycle_rdata,
   output logic                      alternate_master_status_bit,
   output logic      [1:0]           count_zero_irq
);
   if (BUS16 != 0 && BUS16 != 1) begin : g_bad_bus
      $error("BUS16 must be 0 or 1");
   end
   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [19:0] src_reg [2];
   logic [19:0] dst_reg [2];
   logic [15:0] cnt_reg [2];
   logic [14:0] ctl_reg [2];
   logic [1:0]  unit_reg;
   logic [1:0]  pend_reg;
   logic        cur_reg;
   logic        rot_reg;
   logic [2:0]  sub_reg;
   logic [15:0] data_reg;
   logic [2:0]  wait_reg;
   logic [1:0]  sync1_reg, sync2_reg, sync3_reg, pin_reg;
   dma_pkg::xfer_state_t state_reg;
   logic        nmi_q_reg;
   logic        ovr_clr;
   // Channel mode decode
   function automatic logic [1:0] sync_of(input logic [14:0] c);
      sync_of = c[`CTL_SYNC_HI:`CTL_SYNC_LO];
   endfunction
   function automatic logic [19:0] step_of(input logic [14:0] c, input logic inc, input logic dec,
                                           input logic [19:0] p);
      logic [19:0] s;
      s = c[`CTL_WORD] ? 20'h00002 : 20'h00001;
      if (inc && !dec) step_of = p + s;
      else if (dec && !inc) step_of = p - s;
      else step_of = p;
   endfunction
   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   logic wb_hit;
   logic wr_now;
   logic [3:0] widx;
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_now = wb_hit && wb_we_i;
   assign widx = wb_adr_i[5:2];
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_hit;
         if (wb_hit && !wb_we_i) begin
            unique case (wb_adr_i)
               `OFF_SRC0: wb_dat_o <= {12'h000, src_reg[0]};
               `OFF_DST0: wb_dat_o <= {12'h000, dst_reg[0]};
               `OFF_CNT0: wb_dat_o <= {16'h0000, cnt_reg[0]};
               `OFF_CTL0: wb_dat_o <= {17'h00000, ctl_reg[0]};
               `OFF_SRC1: wb_dat_o <= {12'h000, src_reg[1]};
               `OFF_DST1: wb_dat_o <= {12'h000, dst_reg[1]};
               `OFF_CNT1: wb_dat_o <= {16'h0000, cnt_reg[1]};
               `OFF_CTL1: wb_dat_o <= {17'h00000, ctl_reg[1]};
               `OFF_UNIT: wb_dat_o <= {30'h00000000, unit_reg};
               default:   wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
   // ----------------------------------------
   // Request pin synchroniser
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
         sync3_reg <= 2'h0;
         pin_reg   <= 2'h0;
      end else begin
         sync1_reg <= transfer_request_pin;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         // Change counts once stages two and three agree
         pin_reg   <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg | sync3_reg));
      end
   end
   // ----------------------------------------
   // Unit control: suspend and NMI
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         nmi_q_reg <= 1'b0;
      end else begin
         nmi_q_reg <= nmi_active;
      end
   end
   assign ovr_clr = nmi_q_reg && !nmi_active;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         unit_reg <= 2'h0;
      end else if (wr_now && wb_adr_i == `OFF_UNIT && wb_sel_i[0]) begin
         unit_reg <= wb_dat_i[1:0];
      end else if (ovr_clr) begin
         unit_reg[`UNIT_NMI_OVR] <= 1'b0;
      end
   end
   logic run_ok;
   assign run_ok = !unit_reg[`UNIT_SUSPEND] && (!nmi_active || unit_reg[`UNIT_NMI_OVR]);
   // ----------------------------------------
   // Request latches and arbitration
   // ----------------------------------------
   logic [1:0] want;
   logic [1:0] eligible;
   logic       pick;
   logic       end_xfer;
   logic       split;
   logic       last_sub;
   logic       zero_hit;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         eligible[c] = ctl_reg[c][`CTL_ARM] && pend_reg[c];
      end
      eligible = run_ok ? eligible : 2'h0;
      if (ctl_reg[0][`CTL_PRIO] != ctl_reg[1][`CTL_PRIO]) begin
         pick = ctl_reg[1][`CTL_PRIO] ? (eligible[1] ? 1'b1 : 1'b0) : (eligible[0] ? 1'b0 : 1'b1);
      end else begin
         pick = rot_reg ? (eligible[1] ? 1'b1 : 1'b0) : (eligible[0] ? 1'b0 : 1'b1);
      end
   end
   generate
      for (genvar g = 0; g < 2; g++) begin : g_req
         always_comb begin
            unique case (sync_of(ctl_reg[g]))
               dma_pkg::SYNC_NONE: want[g] = ctl_reg[g][`CTL_TIMER] ? 1'b0 : 1'b1;
               default:            want[g] = pin_reg[g];
            endcase
         end
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               pend_reg[g] <= 1'b0;
            end else if (!ctl_reg[g][`CTL_ARM]) begin
               pend_reg[g] <= 1'b0;
            end else if (ctl_reg[g][`CTL_TIMER] && timer_max_pulse) begin
               pend_reg[g] <= 1'b1;
            end else if (state_reg == dma_pkg::ST_DEPO && cycle_start && cur_reg == 1'(g) && last_sub) begin
               pend_reg[g] <= 1'b0;
            end else if (!ctl_reg[g][`CTL_TIMER]) begin
               pend_reg[g] <= want[g];
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // Transfer sequencer
   // ----------------------------------------
   logic [14:0] cc;
   logic [19:0] sp, dp;
   assign cc = ctl_reg[cur_reg];
   assign sp = src_reg[cur_reg];
   assign dp = dst_reg[cur_reg];
   // Odd word splits on 16-bit bus
   assign split = cc[`CTL_WORD] && (BUS16 == 1) && (sp[0] || dp[0]);
   assign last_sub = !split || sub_reg[0];
   assign end_xfer = state_reg == dma_pkg::ST_DEPO && cycle_done && last_sub;
   assign zero_hit = cnt_reg[cur_reg] == 16'h0001;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= dma_pkg::ST_IDLE;
         cur_reg   <= 1'b0;
         sub_reg   <= 3'h0;
         wait_reg  <= 3'h0;
         data_reg  <= 16'h0000;
         rot_reg   <= 1'b1;
      end else begin
         unique case (state_reg)
            dma_pkg::ST_IDLE: begin
               sub_reg <= 3'h0;
               if (eligible != 2'h0) begin
                  cur_reg   <= pick;
                  wait_reg  <= 3'(`REQ_LAT_CLK - 2);
                  state_reg <= dma_pkg::ST_WAIT;
               end else begin
                  rot_reg <= 1'b1;
               end
            end
            dma_pkg::ST_WAIT: begin
               if (wait_reg != 3'h0) wait_reg <= wait_reg - 3'h1;
               else if (bus_grant) state_reg <= dma_pkg::ST_FETCH;
            end
            // Bus held across fetch and deposit
            dma_pkg::ST_FETCH: begin
               if (cycle_done) begin
                  if (split && !sub_reg[0]) data_reg[7:0] <= sp[0] ? cycle_rdata[15:8] : cycle_rdata[7:0];
                  else if (split) data_reg[15:8] <= sp[0] ? cycle_rdata[7:0] : cycle_rdata[15:8];
                  else data_reg <= cycle_rdata;
                  if (split && !sub_reg[0]) sub_reg <= 3'h1;
                  else begin
                     sub_reg   <= 3'h0;
                     state_reg <= dma_pkg::ST_DEPO;
                  end
               end
            end
            dma_pkg::ST_DEPO: begin
               if (cycle_done) begin
                  if (!last_sub) sub_reg <= 3'h1;
                  else state_reg <= dma_pkg::ST_UPD;
               end
            end
            dma_pkg::ST_UPD: begin
               rot_reg <= !cur_reg;
               // Two idle states for destination sync
               if (sync_of(cc) == dma_pkg::SYNC_DST) begin
                  wait_reg  <= 3'h1;
                  state_reg <= dma_pkg::ST_RELSE;
               end else begin
                  state_reg <= dma_pkg::ST_GAP;
               end
            end
            dma_pkg::ST_GAP: state_reg <= dma_pkg::ST_IDLE;
            dma_pkg::ST_RELSE: begin
               rot_reg <= 1'b1;
               if (wait_reg != 3'h0) wait_reg <= wait_reg - 3'h1;
               else state_reg <= dma_pkg::ST_IDLE;
            end
            default: state_reg <= dma_pkg::ST_IDLE;
         endcase
      end
   end
   // ----------------------------------------
   // Channel registers and updates
   // ----------------------------------------
   generate
      for (genvar g = 0; g < 2; g++) begin : g_ch
         logic [7:0] base;
         logic upd;
         assign base = 8'(g * 16);
         assign upd = state_reg == dma_pkg::ST_UPD && cur_reg == 1'(g);
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               src_reg[g] <= 20'h00000;
               dst_reg[g] <= 20'h00000;
               cnt_reg[g] <= 16'h0000;
               ctl_reg[g] <= `CTL_RST;
               count_zero_irq[g] <= 1'b0;
            end else begin
               count_zero_irq[g] <= 1'b0;
               if (wr_now && wb_adr_i == base + `OFF_SRC0) src_reg[g] <= wb_dat_i[19:0];
               // Update after final deposit; 20-bit flat
               else if (upd) src_reg[g] <= step_of(ctl_reg[g], ctl_reg[g][`CTL_SINC], ctl_reg[g][`CTL_SDEC], src_reg[g]);
               if (wr_now && wb_adr_i == base + `OFF_DST0) dst_reg[g] <= wb_dat_i[19:0];
               else if (upd) dst_reg[g] <= step_of(ctl_reg[g], ctl_reg[g][`CTL_DINC], ctl_reg[g][`CTL_DDEC], dst_reg[g]);
               if (wr_now && wb_adr_i == base + `OFF_CNT0) cnt_reg[g] <= wb_dat_i[15:0];
               else if (upd) cnt_reg[g] <= cnt_reg[g] - 16'h0001;
               if (upd && zero_hit) begin
                  count_zero_irq[g] <= ctl_reg[g][`CTL_IRQEN];
                  ctl_reg[g][`CTL_DONE] <= 1'b1;
               end
               // Software disarm takes effect on new starts only
               if (wr_now && wb_adr_i == base + `OFF_CTL0) begin
                  ctl_reg[g] <= {upd && zero_hit, wb_dat_i[13:0]};
               end else if (upd && zero_hit &&
                            (ctl_reg[g][`CTL_TC] || sync_of(ctl_reg[g]) == dma_pkg::SYNC_NONE)) begin
                  ctl_reg[g][`CTL_ARM] <= 1'b0;
               end
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // Bus engine outputs
   // ----------------------------------------
   logic [19:0] addr_now;
   logic        mem_now;
   logic        dep;
   assign dep = state_reg == dma_pkg::ST_DEPO;
   assign addr_now = (dep ? dp : sp) + (split ? {19'h00000, sub_reg[0]} : 20'h00000);
   assign mem_now = dep ? cc[`CTL_DMEM] : cc[`CTL_SMEM];
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cycle_addr     <= 20'h00000;
         cycle_mem      <= 1'b0;
         cycle_write    <= 1'b0;
         cycle_word     <= 1'b0;
         cycle_hi_byte  <= 1'b0;
         cycle_cs_allow <= 1'b0;
         cycle_wdata    <= 16'h0000;
      end else begin
         cycle_addr     <= addr_now;
         cycle_mem      <= mem_now;
         cycle_write    <= dep;
         cycle_word     <= cc[`CTL_WORD] && !split;
         cycle_hi_byte  <= split && sub_reg[0];
         // No chip select above 64K I/O
         cycle_cs_allow <= mem_now || addr_now <= `IO_LIMIT;
         cycle_wdata    <= split ? (sub_reg[0] ? {data_reg[15:8], data_reg[15:8]}
                                               : {data_reg[7:0], data_reg[7:0]}) : data_reg;
      end
   end
   logic in_cyc_reg;
   // Start waits a cycle so registered address fields have settled
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_cyc_reg <= 1'b0;
      end else begin
         in_cyc_reg <= (state_reg == dma_pkg::ST_FETCH || dep) && !cycle_done;
      end
   end
   assign bus_req = state_reg == dma_pkg::ST_WAIT || state_reg == dma_pkg::ST_FETCH || dep;
   assign cycle_start = (state_reg == dma_pkg::ST_FETCH || dep) && in_cyc_reg;
   assign alternate_master_status_bit = state_reg == dma_pkg::ST_FETCH || dep;
endmodule : two_channel_dma_unit
`default_nettype wire

// [verification/dma_unit_monitor.sv]
// Checker for the transfer unit ports
`timescale 1ns/10ps
`default_nettype none
module dma_unit_monitor (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        bus_req,
   input wire logic        cycle_start,
   input wire logic        cycle_done,
   input wire logic [19:0] cycle_addr,
   input wire logic        cycle_mem,
   input wire logic        cycle_write,
   input wire logic        cycle_cs_allow,
   input wire logic        alternate_master_status_bit,
   input wire logic [1:0]  count_zero_irq
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("register access not acknowledged");
   property p_lat;
      $rose(bus_req) |-> !cycle_start [*3];
   endproperty
   a_lat: assert property (p_lat) else $error("bus cycle started too early");
   property p_alt;
      cycle_start |-> alternate_master_status_bit && bus_req;
   endproperty
   a_alt: assert property (p_alt) else $error("status bit low in transfer cycle");
   property p_hold;
      cycle_start && !cycle_done |=> cycle_start;
   endproperty
   a_hold: assert property (p_hold) else $error("bus cycle dropped before done");
   property p_pair;
      cycle_start && cycle_done && !cycle_write |=> bus_req;
   endproperty
   a_pair: assert property (p_pair) else $error("bus freed between fetch and deposit");
   property p_gap;
      $fell(bus_req) |-> !bus_req [*3];
   endproperty
   a_gap: assert property (p_gap) else $error("bus taken back during idle states");
   // Address fields settle one cycle after entry
   property p_cs;
      cycle_start && $past(cycle_start) && !$past(cycle_done) && !cycle_mem && cycle_addr > 20'h0FFFF
         |-> !cycle_cs_allow;
   endproperty
   a_cs: assert property (p_cs) else $error("chip select allowed above I/O limit");
   property p_irq;
      count_zero_irq[0] |=> !count_zero_irq[0];
   endproperty
   a_irq: assert property (p_irq) else $error("count zero pulse too long");
   c_word: cover property (cycle_start && cycle_done && !cycle_write ##2 cycle_start && !cycle_write);
   c_io_hi: cover property (cycle_start && !cycle_mem && cycle_addr > 20'h0FFFF);
   c_irq: cover property (count_zero_irq[0]);
endmodule : dma_unit_monitor
bind two_channel_dma_unit dma_unit_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .bus_req(bus_req), .cycle_start(cycle_start),
   .cycle_done(cycle_done), .cycle_addr(cycle_addr), .cycle_mem(cycle_mem), .cycle_write(cycle_write),
   .cycle_cs_allow(cycle_cs_allow), .alternate_master_status_bit(alternate_master_status_bit),
   .count_zero_irq(count_zero_irq));
`default_nettype wire

// [verification/bus_engine_model.sv]
// Behavioural bus cycle engine facing the unit
`timescale 1ns/10ps
`default_nettype none
module bus_engine_model (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        slow,
   input  wire logic        bus_req,
   input  wire logic        cycle_start,
   input  wire logic [19:0] cycle_addr,
   output logic             bus_grant,
   output logic             cycle_done,
   output logic [15:0]      cycle_rdata
);
   logic [3:0] wait_reg;
   // Grant lags request; slow mode stretches each cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_grant <= 1'b0;
         cycle_done <= 1'b0;
         wait_reg <= 4'h0;
         cycle_rdata <= 16'h0000;
      end else begin
         bus_grant <= bus_req;
         cycle_done <= 1'b0;
         // Data not held outside done: it toggles so stale reads show
         cycle_rdata <= ~cycle_rdata;
         if (cycle_start && !cycle_done) begin
            wait_reg <= wait_reg + 4'h1;
            if (wait_reg == (slow ? 4'h5 : 4'h1)) begin
               cycle_done <= 1'b1;
               cycle_rdata <= cycle_addr[15:0] ^ 16'hA5A5;
               wait_reg <= 4'h0;
            end
         end
      end
   end
endmodule : bus_engine_model
`default_nettype wire

// [verification/tb_top.sv]
// Sequence tests for the transfer unit
`timescale 1ns/10ps
`default_nettype none
`include "dma_cfg.svh"
module tb_top;
   logic sys_clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic wb_ack_o, timer_max_pulse = 1'b0, nmi_active = 1'b0, slow = 1'b0, bus_req, bus_grant;
   logic [1:0] transfer_request_pin = 2'h0, count_zero_irq;
   logic cycle_start, cycle_done, cycle_mem, cycle_write, cycle_word, cycle_hi_byte, cycle_cs_allow, alt;
   logic [19:0] cycle_addr;
   logic [15:0] cycle_wdata, cycle_rdata;
   logic [21:0] lg[$];
   logic [17:0] wd_last = 18'h00000;
   int err_total = 0, tests_run = 0, irq0 = 0, irq1 = 0;
   two_channel_dma_unit u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .transfer_request_pin(transfer_request_pin), .timer_max_pulse(timer_max_pulse),
      .nmi_active(nmi_active), .bus_req(bus_req), .bus_grant(bus_grant), .cycle_start(cycle_start),
      .cycle_done(cycle_done), .cycle_addr(cycle_addr), .cycle_mem(cycle_mem), .cycle_write(cycle_write),
      .cycle_word(cycle_word), .cycle_hi_byte(cycle_hi_byte), .cycle_cs_allow(cycle_cs_allow),
      .cycle_wdata(cycle_wdata), .cycle_rdata(cycle_rdata), .alternate_master_status_bit(alt),
      .count_zero_irq(count_zero_irq));
   bus_engine_model u_eng (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .bus_req(bus_req),
      .cycle_start(cycle_start), .cycle_addr(cycle_addr), .bus_grant(bus_grant), .cycle_done(cycle_done),
      .cycle_rdata(cycle_rdata));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial forever #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (cycle_start === 1'b1 && cycle_done === 1'b1) lg.push_back({cycle_write, cycle_mem, cycle_addr});
      if (cycle_start === 1'b1 && cycle_done === 1'b1 && cycle_write === 1'b1)
         wd_last = {cycle_word, cycle_hi_byte, cycle_wdata};
      if (count_zero_irq[0] === 1'b1) irq0++;
      if (count_zero_irq[1] === 1'b1) irq1++;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      if (n >= 50) chk("ack", 1, 0);
   endtask : wb
   task automatic wait_log(input int n);
      int k;
      for (k = 0; k < 600 && lg.size() < n; k++) @(posedge sys_clk);
      repeat (20) @(posedge sys_clk);
      chk("log size", n, lg.size());
   endtask : wait_log
   task automatic setup(input logic [19:0] s, input logic [19:0] d, input logic [15:0] c, input int ctl);
      lg.delete();
      wb(1, `OFF_SRC0, s);
      wb(1, `OFF_DST0, d);
      wb(1, `OFF_CNT0, c);
      wb(1, `OFF_CTL0, ctl);
   endtask : setup
   initial begin
      #200000;
      err_total++;
      finish_test();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      wb(0, `OFF_CTL0, 0); chk("ctl reset", `CTL_RST, q);
      wb(1, `OFF_SRC0, 32'hFABCD); wb(0, `OFF_SRC0, 0); chk("src ptr", 32'hFABCD, q);
      wb(0, 8'h24, 0); chk("unmapped", 0, q);
      $display("test registers done");
      // Unarmed channel, pin and timer both active
      transfer_request_pin <= 2'h1;
      setup(20'h00010, 20'h00020, 16'h0001, 1 << `CTL_SYNC_LO | 1 << `CTL_TC | 1 << `CTL_SMEM | 1 << `CTL_DMEM);
      @(posedge sys_clk) timer_max_pulse <= 1'b1;
      @(posedge sys_clk) timer_max_pulse <= 1'b0;
      wait_log(0);
      wb(1, `OFF_CTL0, 1 << `CTL_ARM | 1 << `CTL_SYNC_LO | 1 << `CTL_TC | 1 << `CTL_SMEM | 1 << `CTL_DMEM);
      wait_log(2);
      transfer_request_pin <= 2'h0;
      $display("test pin request done");
      // Byte run, memory to I/O above 64K, counting down
      setup(20'h00040, 20'h12345, 16'h0003, 1 << `CTL_ARM | 1 << `CTL_SINC | 1 << `CTL_DDEC | 1 << `CTL_SMEM
         | 1 << `CTL_IRQEN);
      wait_log(6);
      for (int k = 0; k < 3; k++) begin
         chk("fetch", {10'h0, 2'h1, 20'(20'h00040 + k)}, lg[2 * k]);
         chk("deposit", {10'h0, 2'h2, 20'(20'h12345 - k)}, lg[2 * k + 1]);
      end
      chk("wdata", 32'h0A5E7, wd_last);
      wb(0, `OFF_CNT0, 0); chk("count", 0, q);
      wb(0, `OFF_CTL0, 0); chk("armed", 0, q[`CTL_ARM]);
      chk("irq", 1, irq0);
      $display("test byte run done");
      // Odd word on wide bus, slow engine
      // Odd word splits into byte cycles only on the wide bus
      slow <= 1'b1;
      setup(20'h00101, 20'h00200, 16'h0001, 1 << `CTL_ARM | 1 << `CTL_WORD | 1 << `CTL_SINC | 1 << `CTL_DINC
         | 1 << `CTL_SMEM | 1 << `CTL_DMEM);
      wait_log(4);
      chk("split fetch lo", {10'h0, 2'h1, 20'h00101}, lg[0]);
      chk("split fetch hi", {10'h0, 2'h1, 20'h00102}, lg[1]);
      chk("split deposit lo", {10'h0, 2'h3, 20'h00200}, lg[2]);
      chk("split deposit hi", {10'h0, 2'h3, 20'h00201}, lg[3]);
      chk("split wdata", 32'h1A7A7, wd_last);
      wb(0, `OFF_SRC0, 0); chk("src step", 32'h00103, q);
      wb(0, `OFF_DST0, 0); chk("dst step", 32'h00202, q);
      slow <= 1'b0;
      $display("test odd word done");
      // One transfer per timer pulse
      setup(20'h00300, 20'h00400, 16'h0005, 1 << `CTL_ARM | 1 << `CTL_TIMER | 1 << `CTL_TC | 1 << `CTL_SMEM
         | 1 << `CTL_DMEM);
      for (int k = 1; k <= 2; k++) begin
         @(posedge sys_clk) timer_max_pulse <= 1'b1;
         @(posedge sys_clk) timer_max_pulse <= 1'b0;
         wait_log(2 * k);
      end
      wb(0, `OFF_CNT0, 0); chk("timer count", 3, q);
      $display("test timer done");
      // NMI service, then software suspend, hold off a run
      for (int b = 0; b < 2; b++) begin
         if (b == 0) nmi_active <= 1'b1;
         else wb(1, `OFF_UNIT, 1 << `UNIT_SUSPEND);
         setup(20'h00500, 20'h00600, 16'h0002, 1 << `CTL_ARM | 1 << `CTL_SMEM | 1 << `CTL_DMEM);
         wait_log(0);
         if (b == 0) nmi_active <= 1'b0;
         else wb(1, `OFF_UNIT, 0);
         wait_log(4);
      end
      $display("test hold off done");
      // Both channels pending at once, channel 1 destination synchronised
      wb(1, `OFF_UNIT, 1 << `UNIT_SUSPEND);
      transfer_request_pin <= 2'h2;
      setup(20'h00700, 20'h00710, 16'h0001, 1 << `CTL_ARM | 1 << `CTL_SMEM | 1 << `CTL_DMEM);
      wb(1, `OFF_SRC1, 32'h00800);
      wb(1, `OFF_DST1, 32'h00810);
      wb(1, `OFF_CNT1, 32'h00001);
      wb(1, `OFF_CTL1, 1 << `CTL_ARM | 2 << `CTL_SYNC_LO | 1 << `CTL_TC | 1 << `CTL_IRQEN | 1 << `CTL_SMEM
         | 1 << `CTL_DMEM);
      wb(1, `OFF_UNIT, 0);
      wait_log(4);
      chk("rotate first", {10'h0, 2'h1, 20'h00800}, lg[0]);
      chk("rotate second", {10'h0, 2'h1, 20'h00700}, lg[2]);
      chk("irq1", 1, irq1);
      wb(0, `OFF_CTL1, 0);
      chk("done flag", 1, q[`CTL_DONE]);
      chk("armed1", 0, q[`CTL_ARM]);
      transfer_request_pin <= 2'h0;
      $display("test two channels done");
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
